// *** include/acs_cfg.svh ***
// Constants of the conversion sequencer: timing counts, field widths and codes, buffer depth.
// Assumes a 250 MHz system clock and a converter clock enable pulse from a divider.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ACS_CONV_TAD      4'hc
`define ACS_MIN_ACQ_TAD   4'h2
`define ACS_TAD_DIV_W     4
`define ACS_TRIG_DLY_NS   8'h0a
`define ACS_CLK_NS        8'h04
`define ACS_PWRUP_CYC     12'h4e2
`define ACS_TRIG_DLY_CYC  ((`ACS_TRIG_DLY_NS + `ACS_CLK_NS - 8'h01) / `ACS_CLK_NS)

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define ACS_TRIG_W        5
`define ACS_ACQ_W         4
`define ACS_DEPTH_EVERY   2'h0
`define ACS_DEPTH_2_4     2'h1
`define ACS_DEPTH_4       2'h2
`define ACS_RES_W         10
`define ACS_WORDS         4

`endif

// *** include/acs_pkg.sv ***
// Types of the conversion sequencer.
// Assumes acs_cfg.svh is in the include path.
package acs_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACQ  = 4'b0010,
    ST_CONV = 4'b0100,
    ST_DONE = 4'b1000
  } acs_state_t;

endpackage

// *** rtl/acs_sequencer.sv ***
// Sample-then-convert sequencer of a 10-bit converter, controlled through plain ports.
// Assumes all inputs are synchronous to CLK and trigger inputs are single-cycle events.
//
// Overview of operation
// - Sample at least two converter clocks.
// - Acquisition field of two or more sets sample length.
// - Single-shot clears busy bit at finish.
// - Interrupt flag set on completion.
// - Buffer-empty clears after first stored result.
// - Conversion lasts exactly twelve converter clocks.
// - Trigger to conversion at least quarter cycle.
// - Five trigger enables; zero disables all.
// - Trigger sets busy, single-shot completion clears it.
// - Depth field chooses continuous-loop interrupt timing.
`include "acs_cfg.svh"
module acs_sequencer
(
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RST,
  // Configuration
  input  wire logic                      CONV_POWER_ON,
  input  wire logic                      CONT_LOOP,
  input  wire logic [`ACS_TAD_DIV_W-1:0] TAD_DIV,
  input  wire logic [`ACS_ACQ_W-1:0]     ACQ_PERIOD,
  input  wire logic [`ACS_TRIG_W-1:0]    TRIGGER_SELECT,
  input  wire logic [1:0]                BUF_DEPTH_IRQ_SEL,
  // Software strobes
  input  wire logic                      SW_START,
  input  wire logic                      SW_STOP,
  input  wire logic                      IRQ_FLAG_CLR,
  input  wire logic                      BUF_READ,
  // Hardware trigger events
  input  wire logic [`ACS_TRIG_W-1:0]    TRIG_EVENT,
  // Analog front end
  input  wire logic [`ACS_RES_W-1:0]     CONV_DATA,
  output logic                           SAMPLE_EN,
  output logic                           CONVERT_EN,
  // Status
  output logic                           CONV_BUSY,
  output logic                           CONV_IRQ_FLAG,
  output logic                           RESULT_BUF_EMPTY,
  output logic [`ACS_RES_W-1:0]          RESULT_DATA
);

  acs_pkg::acs_state_t       state_q;
  logic                      tick;
  logic [3:0]                cnt_q;
  logic [1:0]                wptr_q;
  logic [1:0]                rptr_q;
  logic [2:0]                nwords_q;
  logic [`ACS_RES_W-1:0]     buf_q [`ACS_WORDS];
  logic [`ACS_TRIG_W-1:0]    trig_hit;
  logic                      start;
  logic                      dly_q;
  logic                      word_done;
  logic                      irq_evt;
  logic [3:0]                acq_len;

  // --------------------------------------------------------------------------
  // Start decision
  // --------------------------------------------------------------------------
  // Each trigger source has its own enable bit.
  genvar g;
  generate
    for (g = 0; g < `ACS_TRIG_W; g++)
    begin : g_trig
      assign trig_hit[g] = TRIGGER_SELECT[g] & TRIG_EVENT[g];
    end
  endgenerate

  // Starts outside the idle state are dropped.
  assign start = CONV_POWER_ON && (state_q == acs_pkg::ST_IDLE) && (SW_START || (|trig_hit));

  // The field counts converter clocks; below the floor the floor applies.
  assign acq_len = (ACQ_PERIOD < `ACS_MIN_ACQ_TAD) ? `ACS_MIN_ACQ_TAD : ACQ_PERIOD;

  assign word_done = (state_q == acs_pkg::ST_CONV) && tick && (cnt_q == `ACS_CONV_TAD - 4'h1);

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // SAMPLE_EN rises two system clocks after start, so conversion always trails a
  // trigger by far more than a quarter instruction cycle.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= acs_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
    end
    else if (!CONV_POWER_ON)
    begin
      state_q <= acs_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
    end
    else
    begin
      case (state_q)
        acs_pkg::ST_IDLE:
        begin
          cnt_q <= 4'h0;
          if (start)
          begin
            state_q <= acs_pkg::ST_ACQ;
          end
        end
        acs_pkg::ST_ACQ:
        begin
          if (tick)
          begin
            if (cnt_q == acq_len - 4'h1)
            begin
              cnt_q   <= 4'h0;
              state_q <= acs_pkg::ST_CONV;
            end
            else
            begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        acs_pkg::ST_CONV:
        begin
          if (word_done)
          begin
            cnt_q   <= 4'h0;
            state_q <= acs_pkg::ST_DONE;
          end
          else if (tick)
          begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        acs_pkg::ST_DONE:
        begin
          // Continuous loop resamples until software stops it.
          if (CONT_LOOP && !SW_STOP)
          begin
            state_q <= acs_pkg::ST_ACQ;
          end
          else
          begin
            state_q <= acs_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_q <= acs_pkg::ST_IDLE;
          cnt_q   <= 4'h0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Outputs to the front end and busy bit
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      SAMPLE_EN  <= 1'b0;
      CONVERT_EN <= 1'b0;
      CONV_BUSY  <= 1'b0;
      dly_q      <= 1'b0;
    end
    else
    begin
      SAMPLE_EN  <= CONV_POWER_ON && (state_q == acs_pkg::ST_ACQ);
      CONVERT_EN <= CONV_POWER_ON && (state_q == acs_pkg::ST_CONV);
      dly_q      <= start;
      if (start)
      begin
        CONV_BUSY <= 1'b1;
      end
      else if (!CONV_POWER_ON || (state_q == acs_pkg::ST_IDLE && !dly_q))
      begin
        CONV_BUSY <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Result buffer and interrupt flag
  // --------------------------------------------------------------------------
  // The stored word only changes when written, so no reset is needed here.
  always_ff @(posedge CLK)
  begin
    if (word_done)
    begin
      buf_q[wptr_q] <= CONV_DATA;
    end
  end

  // Continuous loop picks its interrupt by the depth field; single-shot ignores it.
  always_comb
  begin
    irq_evt = 1'b0;
    if (word_done)
    begin
      if (!CONT_LOOP)
      begin
        irq_evt = 1'b1;
      end
      else
      begin
        case (BUF_DEPTH_IRQ_SEL)
          `ACS_DEPTH_EVERY: irq_evt = 1'b1;
          `ACS_DEPTH_2_4:   irq_evt = wptr_q[0];
          `ACS_DEPTH_4:     irq_evt = (wptr_q == 2'h3);
          default:          irq_evt = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      CONV_IRQ_FLAG <= 1'b0;
    end
    else if (irq_evt)
    begin
      CONV_IRQ_FLAG <= 1'b1;
    end
    else if (IRQ_FLAG_CLR)
    begin
      CONV_IRQ_FLAG <= 1'b0;
    end
  end

  // A write in the same cycle as a read leaves the count unchanged.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wptr_q           <= 2'h0;
      rptr_q           <= 2'h0;
      nwords_q         <= 3'h0;
      RESULT_BUF_EMPTY <= 1'b1;
      RESULT_DATA      <= '0;
    end
    else
    begin
      if (word_done)
      begin
        wptr_q <= wptr_q + 2'h1;
      end
      if (BUF_READ && nwords_q != 3'h0)
      begin
        rptr_q      <= rptr_q + 2'h1;
        RESULT_DATA <= buf_q[rptr_q];
      end
      if (word_done && !(BUF_READ && nwords_q != 3'h0) && nwords_q != 3'h4)
      begin
        nwords_q         <= nwords_q + 3'h1;
        RESULT_BUF_EMPTY <= 1'b0;
      end
      else if (!word_done && BUF_READ && nwords_q != 3'h0)
      begin
        nwords_q         <= nwords_q - 3'h1;
        RESULT_BUF_EMPTY <= (nwords_q == 3'h1);
      end
    end
  end

  acs_tad_gen u_tad
  (
    .clk  (CLK),
    .rst  (RST),
    .run  (CONV_POWER_ON),
    .div  (TAD_DIV),
    .tick (tick)
  );

endmodule

// *** rtl/acs_tad_gen.sv ***
// Converter clock generator: one-cycle pulse every (div+1) system clocks.
// Assumes the divider value is steady while the converter is powered.
`include "acs_cfg.svh"
module acs_tad_gen
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Control
  input  wire logic                      run,
  input  wire logic [`ACS_TAD_DIV_W-1:0] div,
  // Converter clock tick
  output logic                           tick
);

  logic [`ACS_TAD_DIV_W-1:0] cnt_q;

  // Held in reset while powered off.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else if (cnt_q == div)
    begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule

// *** testbench/acs_seq_monitor.sv ***
// Checker of the sequencer: start, sample, convert and status timing.
// Assumes it is bound to acs_sequencer and sees only its ports.
`include "acs_cfg.svh"
module acs_seq_monitor
(
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RST,
  // Inputs watched
  input  wire logic                      CONV_POWER_ON,
  input  wire logic                      CONT_LOOP,
  input  wire logic [`ACS_TAD_DIV_W-1:0] TAD_DIV,
  input  wire logic [`ACS_ACQ_W-1:0]     ACQ_PERIOD,
  input  wire logic [`ACS_TRIG_W-1:0]    TRIGGER_SELECT,
  input  wire logic                      SW_START,
  input  wire logic                      IRQ_FLAG_CLR,
  input  wire logic [`ACS_TRIG_W-1:0]    TRIG_EVENT,
  // Outputs watched
  input  wire logic                      SAMPLE_EN,
  input  wire logic                      CONVERT_EN,
  input  wire logic                      CONV_BUSY,
  input  wire logic                      CONV_IRQ_FLAG,
  input  wire logic                      RESULT_BUF_EMPTY
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic [7:0] conv_cnt_q;
  logic [7:0] samp_cnt_q;
  logic [7:0] conv_len;
  logic [7:0] acq_len;
  logic [7:0] acq_min;
  assign conv_len = 8'(`ACS_CONV_TAD) * (8'(TAD_DIV) + 8'h01);
  assign acq_len = (ACQ_PERIOD < `ACS_MIN_ACQ_TAD) ? 8'h02 : 8'(ACQ_PERIOD);
  assign acq_min = (acq_len - 8'h01) * (8'(TAD_DIV) + 8'h01) + 8'h01;
  always_ff @(posedge CLK or posedge RST)
    if (RST)
      conv_cnt_q <= 8'h00;
    else
      conv_cnt_q <= CONVERT_EN ? conv_cnt_q + 8'h01 : 8'h00;
  always_ff @(posedge CLK or posedge RST)
    if (RST)
      samp_cnt_q <= 8'h00;
    else
      samp_cnt_q <= SAMPLE_EN ? samp_cnt_q + 8'h01 : 8'h00;
  sequence s_sw_start;
    CONV_POWER_ON && !CONV_BUSY && SW_START;
  endsequence
  sequence s_hw_start;
    CONV_POWER_ON && !CONV_BUSY && |(TRIGGER_SELECT & TRIG_EVENT);
  endsequence
  sequence s_launch;
    CONV_BUSY ##1 SAMPLE_EN;
  endsequence
  a_sw_start_run: assert property (s_sw_start |=> s_launch)
    else $error("software start did not launch a sample");
  a_hw_start_run: assert property (s_hw_start |=> s_launch)
    else $error("trigger did not launch a sample");
  a_no_cause_idle: assert property (!CONV_BUSY && !SW_START &&
    (TRIGGER_SELECT & TRIG_EVENT) == '0 |=> !CONV_BUSY)
    else $error("busy rose without a start");
  a_acq_min_len: assert property ($fell(SAMPLE_EN) && CONV_POWER_ON
    |-> samp_cnt_q >= acq_min)
    else $error("sampling too short");
  a_conv_follows: assert property ($fell(SAMPLE_EN) && CONV_POWER_ON
    |-> ##[0:1] CONVERT_EN)
    else $error("conversion did not follow sampling");
  a_conv_twelve: assert property ($fell(CONVERT_EN) && CONV_POWER_ON
    |-> conv_cnt_q == conv_len)
    else $error("conversion length wrong");
  a_irq_on_done: assert property ($fell(CONVERT_EN) && CONV_POWER_ON
    && !CONT_LOOP |-> ##[1:2] CONV_IRQ_FLAG)
    else $error("flag not set after conversion");
  a_buf_filled: assert property ($fell(CONVERT_EN) && CONV_POWER_ON
    |-> ##[1:2] !RESULT_BUF_EMPTY)
    else $error("buffer still empty after conversion");
  a_busy_ends: assert property ($fell(CONVERT_EN) && !CONT_LOOP
    |-> ##[1:5] !CONV_BUSY)
    else $error("busy not cleared after single shot");
  a_flag_holds: assert property (CONV_IRQ_FLAG && !IRQ_FLAG_CLR
    |=> CONV_IRQ_FLAG)
    else $error("flag dropped without clear");
  a_off_idle: assert property (!CONV_POWER_ON [*3]
    |-> !CONV_BUSY && !SAMPLE_EN && !CONVERT_EN)
    else $error("activity while powered off");
endmodule
bind acs_sequencer acs_seq_monitor mon (.CLK, .RST, .CONV_POWER_ON, .CONT_LOOP,
  .TAD_DIV, .ACQ_PERIOD, .TRIGGER_SELECT, .SW_START, .IRQ_FLAG_CLR, .TRIG_EVENT,
  .SAMPLE_EN, .CONVERT_EN, .CONV_BUSY, .CONV_IRQ_FLAG, .RESULT_BUF_EMPTY);

// *** testbench/acs_trig_src.sv ***
// Model of the hardware trigger sources: single-cycle events on request.
// Assumes the bench calls fire() while it drives on falling edges.
`include "acs_cfg.svh"
module acs_trig_src
(
  // Clock
  input  wire logic                  clk,
  // Trigger events
  output logic [`ACS_TRIG_W-1:0]     ev
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  initial ev = '0;
  // One clean pulse per event, since a held level would start again.
  task automatic fire(input logic [`ACS_TRIG_W-1:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = '0;
  endtask
endmodule

// *** testbench/tb.sv ***
// Bench of the sequencer: single shots, triggers, power cut, loop depths.
// Assumes the trigger model and the bound checker are compiled first.
`include "acs_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      pwr = 1'b0;
  logic                      lp = 1'b0;
  logic [`ACS_TAD_DIV_W-1:0] div = '0;
  logic [`ACS_ACQ_W-1:0]     acq = '0;
  logic [`ACS_TRIG_W-1:0]    tsel = '0;
  logic [1:0]                depth = '0;
  logic                      start = 1'b0;
  logic                      stop = 1'b0;
  logic                      fclr = 1'b0;
  logic                      rd = 1'b0;
  logic [`ACS_TRIG_W-1:0]    ev;
  logic [`ACS_RES_W-1:0]     din = '0;
  logic                      samp;
  logic                      conv;
  logic                      busy;
  logic                      flag;
  logic                      empty;
  logic [`ACS_RES_W-1:0]     dout;
  int                        n_errors = 0;
  int                        n_compared = 0;
  int                        cycles = 0;
  acs_trig_src src (.clk(clk), .ev(ev));
  acs_sequencer dut (.CLK(clk), .RST(rst), .CONV_POWER_ON(pwr), .CONT_LOOP(lp),
    .TAD_DIV(div), .ACQ_PERIOD(acq), .TRIGGER_SELECT(tsel), .BUF_DEPTH_IRQ_SEL(depth),
    .SW_START(start), .SW_STOP(stop), .IRQ_FLAG_CLR(fclr), .BUF_READ(rd),
    .TRIG_EVENT(ev), .CONV_DATA(din), .SAMPLE_EN(samp), .CONVERT_EN(conv),
    .CONV_BUSY(busy), .CONV_IRQ_FLAG(flag), .RESULT_BUF_EMPTY(empty), .RESULT_DATA(dout));
  always #2 clk = ~clk;
  // The whole run needs a few thousand cycles; the ceiling only cuts a hang.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic reset_dut();
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    pwr = 1'b1;
    repeat (`ACS_PWRUP_CYC) @(negedge clk);
  endtask
  task automatic wait_done(output int ns, output int nc);
    ns = 0;
    nc = 0;
    while (busy === 1'b1 && ns + nc < 500)
    begin
      start = (nc == 3);
      @(negedge clk);
      ns += samp;
      nc += conv;
    end
    start = 1'b0;
  endtask
  task automatic finish_word(input logic [`ACS_RES_W-1:0] w);
    chk(busy, 1'b0);
    chk(flag, 1'b1);
    chk(empty, 1'b0);
    pulse(rd);
    chk(dout, w);
    chk(empty, 1'b1);
    pulse(fclr);
    chk(flag, 1'b0);
  endtask
  task automatic single(input logic [3:0] a, input logic [3:0] d);
    int ns, nc, want;
    acq = a;
    div = d;
    din = {a, d, 2'h1};
    pulse(start);
    chk(busy, 1'b1);
    wait_done(ns, nc);
    want = ((a < 2 ? 2 : a) - 1) * (d + 1) + 1;
    chk(ns >= want, 1'b1);
    chk(nc, 12 * (d + 1));
    finish_word({a, d, 2'h1});
  endtask
  task automatic triggers();
    int ns, nc;
    acq = 4'h0;
    div = 4'h0;
    tsel = '0;
    src.fire(5'h1f);
    chk(busy, 1'b0);
    for (int i = 0; i < `ACS_TRIG_W; i++)
    begin
      din = 10'h3c0 + i;
      tsel = ~(5'h01 << i);
      src.fire(5'h01 << i);
      @(negedge clk);
      chk(busy, 1'b0);
      tsel = 5'h01 << i;
      src.fire(5'h01 << i);
      chk(busy, 1'b1);
      wait_done(ns, nc);
      finish_word(10'h3c0 + i);
    end
  endtask
  task automatic power_cut();
    pulse(start);
    repeat (6) @(negedge clk);
    pwr = 1'b0;
    repeat (3) @(negedge clk);
    chk({busy, samp, conv}, 3'h0);
    pulse(start);
    chk(busy, 1'b0);
  endtask
  task automatic loops();
    int w;
    logic last;
    for (int d = 0; d < 4; d++)
    begin
      lp = 1'b1;
      depth = d[1:0];
      reset_dut();
      w = 0;
      last = 1'b0;
      pulse(start);
      while (flag !== 1'b1 && w < 6)
      begin
        @(negedge clk);
        w += (!last && conv);
        last = conv;
      end
      chk(w, d == 0 ? 1 : (d == 3 ? 6 : 2 * d));
      stop = 1'b1;
      for (int k = 0; k < 200 && busy === 1'b1; k++)
        @(negedge clk);
      chk(busy, 1'b0);
      stop = 1'b0;
      lp = 1'b0;
    end
  endtask
  initial
  begin
    reset_dut();
    chk({busy, flag, empty}, 3'h1);
    single(4'h0, 4'h0);
    single(4'h1, 4'h0);
    single(4'h5, 4'h1);
    single(4'hc, 4'h2);
    triggers();
    power_cut();
    loops();
    end_of_test();
  end
endmodule
